// [design/stc_chan.sv]
// one counter channel: rate generator or square wave, 16-bit binary
// assumes a one-cycle tick marks each rising edge of its counting clock
`default_nettype none
`include "stc_regs.svh"
module stc_chan
	import stc_pkg::*;
#(
	parameter int CW = `STC_CNT_W
) (
	input  wire logic          clk,      // system clock
	input  wire logic          nrst,     // sync reset, low
	input  wire logic          tick,     // counting clock edge
	input  wire logic          wr,       // program strobe
	input  wire stc_mode_t     mode_in,  // mode written
	input  wire logic [CW-1:0] count_in, // count written, 0 means 2^CW
	output logic               out,      // channel output
	output logic               pulse     // one cycle per period end
);
	typedef struct packed {
		stc_mode_t     mode;
		logic [CW-1:0] load;
		logic [CW-1:0] cnt;
		logic          armed;
		logic          out;
		logic          pulse;
	} stc_chan_st_t;
	stc_chan_st_t st_r, st_nxt;
	logic [CW-1:0] half;
	// half of the load; a zero load stands for 2^CW, so its half is the top bit alone
	assign half = {st_r.load == '0, st_r.load[CW-1:1]};
	////////////////////////////////////////////////////////////////
	// counting; zero load wraps through full range so acts as 2^CW
	always_comb begin
		st_nxt = st_r;
		st_nxt.pulse = 1'b0;
		if (wr) begin
			st_nxt.mode  = mode_in;
			st_nxt.load  = count_in;
			st_nxt.cnt   = count_in;
			// only the two counting modes arm; an unused code leaves the channel idle
			st_nxt.armed = (mode_in == STC_MODE_RATE) || (mode_in == STC_MODE_SQR);
			st_nxt.out   = (mode_in == STC_MODE_RATE) || (mode_in == STC_MODE_SQR);
		end else if (st_r.armed && tick) begin
			unique case (st_r.mode)
				STC_MODE_RATE: begin
					if (st_r.cnt == CW'(2)) begin
						st_nxt.out = 1'b0;
						st_nxt.cnt = st_r.cnt - CW'(1);
					end else if (st_r.cnt == CW'(1)) begin
						st_nxt.out   = 1'b1;
						st_nxt.pulse = 1'b1;
						st_nxt.cnt   = st_r.load;
					end else begin
						st_nxt.out = 1'b1;
						st_nxt.cnt = st_r.cnt - CW'(1);
					end
				end
				STC_MODE_SQR: begin
					// high for ceil(n/2), low for floor(n/2); a count of 1 gives one tick high, one tick low
					if (st_r.cnt == CW'(1)) begin
						st_nxt.out = ~st_r.out;
						st_nxt.cnt = st_r.load;
						st_nxt.pulse = ~st_r.out;
					end else if (st_r.cnt == half + CW'(1)
						&& st_r.out && st_r.load != CW'(1)) begin
						st_nxt.out = 1'b0;
						st_nxt.cnt = half;
					end else begin
						st_nxt.cnt = st_r.cnt - CW'(1);
					end
				end
				default: begin
					st_nxt.armed = 1'b0;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign out   = st_r.out;
	assign pulse = st_r.pulse;
endmodule
`default_nettype wire

// [design/stc_regs.svh]
// constants for the three channel system timer
// assumes inclusion by bare name from the design files
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
`define STC_CNT_W        16
`define STC_NUM_CH       3
`define STC_KB_CH        0
`define STC_BAUD_CH      1
`define STC_INT_CH       2
`define STC_CNT_RST      16'h0000
`define STC_MODE_RST     2'h0
`define STC_PCLK_KHZ     2457.6
`define STC_CLK_MHZ      200
`endif

// [design/stc_pkg.sv]
// types shared by the system timer files
// assumes stc_regs.svh on the include path
`default_nettype none
`include "stc_regs.svh"
package stc_pkg;
	typedef enum logic [1:0] {
		STC_MODE_NONE = 2'h0,
		STC_MODE_RATE = 2'h2,
		STC_MODE_SQR  = 2'h3
	} stc_mode_t;
	// one channel program write
	typedef struct packed {
		logic                  wr;
		logic [1:0]            ch;
		stc_mode_t             mode;
		logic [`STC_CNT_W-1:0] count;
	} stc_prog_t;
	// channel outputs
	typedef struct packed {
		logic kb_rate;
		logic baud;
		logic irq;
	} stc_out_t;
endpackage
`default_nettype wire

// [design/stc_top.sv]
// three channel system timer: keyboard clock, baud clock, interval irq
// assumes PCLK_TICK marks each rising edge of the peripheral clock
`default_nettype none
`include "stc_regs.svh"
module stc_top
	import stc_pkg::*;
#(
	parameter int NCH = `STC_NUM_CH
) (
	input  wire logic                  CLK,           // 200 MHz clock
	input  wire logic                  NRST,          // sync reset, low
	input  wire logic                  PCLK_TICK,     // peripheral clock edge
	input  wire stc_prog_t             PROG,          // channel program write
	output logic                       KEYBOARD_RATE_CLOCK, // channel 0 out
	output logic                       BAUD_CLOCK,    // channel 1 out
	output logic                       TIMER_IRQ      // channel 2 period-end pulse
);
	typedef struct packed {
		logic     kb_d;
		stc_out_t o;
	} stc_top_st_t;
	stc_top_st_t st_r, st_nxt;
	logic [NCH-1:0] ch_out;
	logic [NCH-1:0] ch_pulse;
	logic [NCH-1:0] ch_tick;
	////////////////////////////////////////////////////////////////
	// clock routing; channel 2 counts on rising edges of channel 0 out
	assign ch_tick[`STC_KB_CH]   = PCLK_TICK;
	assign ch_tick[`STC_BAUD_CH] = PCLK_TICK;
	assign ch_tick[`STC_INT_CH]  = ch_out[`STC_KB_CH] & ~st_r.kb_d;
	////////////////////////////////////////////////////////////////
	// channels share one program bus, picked by channel index; channel 2 is clocked by channel 0
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		stc_chan u_ch (
			.clk      (CLK),
			.nrst     (NRST),
			.tick     (ch_tick[i]),
			.wr       (PROG.wr && PROG.ch == 2'(i)),
			.mode_in  (PROG.mode),
			.count_in (PROG.count),
			.out      (ch_out[i]),
			.pulse    (ch_pulse[i])
		);
	end
	////////////////////////////////////////////////////////////////
	// output staging; irq follows the channel 2 period-end pulse, one per period
	always_comb begin
		st_nxt = st_r;
		st_nxt.kb_d      = ch_out[`STC_KB_CH];
		st_nxt.o.kb_rate = ch_out[`STC_KB_CH];
		st_nxt.o.baud    = ch_out[`STC_BAUD_CH];
		st_nxt.o.irq     = ch_pulse[`STC_INT_CH];
	end
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign KEYBOARD_RATE_CLOCK = st_r.o.kb_rate;
	assign BAUD_CLOCK          = st_r.o.baud;
	assign TIMER_IRQ           = st_r.o.irq;
endmodule
`default_nettype wire

// [verification/stc_top_props.sv]
// port checker for the three channel timer
// assumes it is bound onto stc_top
`default_nettype none
module stc_top_props
	import stc_pkg::*;
(
	input wire logic      CLK,                 // clock
	input wire logic      NRST,                // reset, low
	input wire logic      PCLK_TICK,           // tick
	input wire stc_prog_t PROG,                // write
	input wire logic      KEYBOARD_RATE_CLOCK, // ch0
	input wire logic      BAUD_CLOCK,          // ch1
	input wire logic      TIMER_IRQ            // ch2
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic armed_r;
	// irq is legal only once channel 2 has been written
	always_ff @(posedge CLK) begin
		if (!NRST)
			armed_r <= 1'b0;
		else if (PROG.wr && PROG.ch == 2'h2)
			armed_r <= 1'b1;
	end
	////////////////////////////////////////////////////////////
	AST_RST_IDLE: assert property (disable iff (1'b0) !NRST |=>
		!KEYBOARD_RATE_CLOCK && !BAUD_CLOCK && !TIMER_IRQ) else $error("busy in reset");
	AST_KB_START: assert property (PROG.wr && PROG.ch == 2'h0 &&
		PROG.mode == STC_MODE_SQR |-> ##2 KEYBOARD_RATE_CLOCK) else $error("kb no start");
	AST_BAUD_START: assert property (PROG.wr && PROG.ch == 2'h1 &&
		PROG.mode == STC_MODE_SQR |-> ##2 BAUD_CLOCK) else $error("baud no start");
	AST_BAUD_STOP: assert property (PROG.wr && PROG.ch == 2'h1 &&
		PROG.mode == STC_MODE_NONE |-> ##2 !BAUD_CLOCK) else $error("baud no stop");
	AST_IRQ_ONE: assert property (TIMER_IRQ |=> !TIMER_IRQ) else $error("irq too long");
	AST_IRQ_ARMED: assert property (TIMER_IRQ |-> armed_r) else $error("irq unarmed");
	AST_BAUD_EDGE: assert property ($past(NRST) && $changed(BAUD_CLOCK) |->
		$past(PCLK_TICK, 2) || $past(PROG.wr, 2)) else $error("baud off tick");
	AST_KB_EDGE: assert property ($past(NRST) && $changed(KEYBOARD_RATE_CLOCK) |->
		$past(PCLK_TICK, 2) || $past(PROG.wr, 2)) else $error("kb off tick");
endmodule
bind stc_top stc_top_props props_u (.CLK(CLK), .NRST(NRST), .PCLK_TICK(PCLK_TICK),
	.PROG(PROG), .KEYBOARD_RATE_CLOCK(KEYBOARD_RATE_CLOCK), .BAUD_CLOCK(BAUD_CLOCK),
	.TIMER_IRQ(TIMER_IRQ));
`default_nettype wire

// [verification/stc_far.sv]
// far side: serial controllers and cpu, timing rises of each clock
// assumes outputs are sampled on the system clock
`default_nettype none
module stc_far (
	input  wire logic [2:0]  sig,     // kb, baud, irq
	input  wire logic        clk,     // system clock
	output logic      [15:0] per [3]  // cycles between rises
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] cnt [3] = '{3{16'h0}};
	logic [2:0]  last = 3'h0;
	//////////////////////////////////////////////
	// controllers act on rising edges only, so only those are timed
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			cnt[i] = cnt[i] + 16'h1;
			if (sig[i] && !last[i]) begin
				per[i] = cnt[i];
				cnt[i] = 16'h0;
			end
		end
		last = sig;
	end
endmodule
`default_nettype wire

// [verification/stc_top_test.sv]
// testbench for the three channel timer
// assumes stc_far as the far side and the bound checker
`default_nettype none
module stc_top_test;
	import stc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        CLK = 1'b0;
	logic        NRST = 1'b0;
	logic        PCLK_TICK = 1'b0;
	stc_prog_t   PROG = '0;
	logic        kb, baud, irq;
	logic [15:0] per [3];
	int          fails, n_compared, cyc;
	stc_top dut_u (.CLK(CLK), .NRST(NRST), .PCLK_TICK(PCLK_TICK), .PROG(PROG),
		.KEYBOARD_RATE_CLOCK(kb), .BAUD_CLOCK(baud), .TIMER_IRQ(irq));
	stc_far far_u (.sig({kb, baud, irq}), .clk(CLK), .per(per));
	//////////////////////////////////////////////
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	// tick every fourth cycle: short periods, still far apart
	always @(negedge CLK) begin
		cyc++;
		PCLK_TICK = (cyc % 4 == 0);
		if (cyc > 20000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic prog(input logic [1:0] ch, input stc_mode_t m, input logic [15:0] n);
		@(negedge CLK);
		PROG = {1'b1, ch, m, n};
		@(negedge CLK);
		PROG.wr = 1'b0;
	endtask
	task automatic t_idle();
		repeat (50) @(negedge CLK);
		check(16'({kb, baud, irq}), 16'h0);
	endtask
	task automatic t_rates();
		prog(2'h0, STC_MODE_SQR, 16'h80);
		prog(2'h1, STC_MODE_SQR, 16'h10);
		repeat (1200) @(negedge CLK);
		check(per[2], 16'h200);
		check(per[1], 16'h40);
	endtask
	// odd divisor: high one tick longer than low, period still the full count
	task automatic t_odd();
		prog(2'h1, STC_MODE_SQR, 16'h11);
		repeat (250) @(negedge CLK);
		check(per[1], 16'h44);
	endtask
	task automatic t_irq();
		prog(2'h0, STC_MODE_SQR, 16'h4);
		prog(2'h2, STC_MODE_RATE, 16'h3);
		repeat (300) @(negedge CLK);
		check(per[2], 16'h10);
		check(per[0], 16'h30);
	endtask
	task automatic t_stop();
		prog(2'h1, STC_MODE_NONE, 16'h10);
		repeat (20) @(negedge CLK);
		check(16'(baud), 16'h0);
	endtask
	task automatic wrap_up();
		$display("compared %0d errors %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge CLK);
		NRST = 1'b1;
		t_idle();
		t_rates();
		t_odd();
		t_irq();
		t_stop();
		wrap_up();
	end
endmodule
`default_nettype wire
